// File: src/scr_pkg.sv
// Constants for the synthesizer configuration register bank.
// Assumes a single core sync clock and a host that holds the byte port stable across a write.
//
// Contract
// - 28 word registers from index zero; byte port shows them as 112 byte registers.
// - Values written to the three registers the bank decodes itself wait in a buffer; transfer strobe or profile change applies them.
// - Master reset returns every register to its default value.
// - Control bit 24 starts oscillator calibration; host clears it before another.
// - Streaming bit zero: parallel words are accepted only on a transfer strobe or profile change.
// - Streaming bit one: parallel inputs sampled every clock edge and applied to the word the select pins pick.
// - Function select pins steer sampled data; host changes them synchronously.
// - Control bit 16 zero routes the cosine output to the converter.
// - Control bit 16 one routes the sine output; one after reset.
// - Profile seven holds 16-bit phase, 12-bit amplitude above, top four bits unused.
// - User sync low byte holds 3-bit sync-out and sync-in delay fields.
package scr_pkg;

  // Register geometry.
  localparam logic [4:0] REG_COUNT = 5'h1c;
  localparam logic [6:0] BYTE_COUNT = 7'h70;
  localparam int BYTE_AW = 7;
  localparam int IDX_W = 5;

  // Word indices of the registers this bank decodes itself.
  localparam logic [4:0] IDX_CONTROL_WORD_ONE = 5'h00;
  localparam logic [4:0] IDX_PROFILE_SEVEN_PA = 5'h1a;
  localparam logic [4:0] IDX_USER_SYNC_CONTROL = 5'h1b;

  // Reset values.
  localparam logic [31:0] RST_CONTROL_WORD_ONE = 32'h0001_0000;
  localparam logic [31:0] RST_PROFILE_SEVEN_PA = 32'h0000_0000;
  localparam logic [31:0] RST_USER_SYNC_CONTROL = 32'h0000_0800;
  localparam logic [31:0] RST_OTHER = 32'h0000_0000;

  // Writable bit masks; zeros are open positions.
  localparam logic [31:0] MASK_CONTROL_WORD_ONE = 32'h0103_fbff;
  localparam logic [31:0] MASK_PROFILE_SEVEN_PA = 32'h0fff_ffff;
  localparam logic [31:0] MASK_USER_SYNC_CONTROL = 32'h00ff_ff7f;

  // Field positions.
  localparam int BIT_OSC_CAL_START = 24;
  localparam int BIT_STREAM_ENABLE = 17;
  localparam int BIT_SINE_SELECT = 16;
  localparam int BIT_PLL_LOCK = 24;
  localparam int BIT_CAL_WITH_SYNC = 6;
  localparam int POS_SYNC_OUT_DELAY = 3;
  localparam int POS_SYNC_IN_DELAY = 0;
  localparam int DELAY_W = 3;
  localparam int POS_PHASE = 0;
  localparam int PHASE_W = 16;
  localparam int POS_AMP = 16;
  localparam int AMP_W = 12;
  localparam int FREQ_W = 32;
  localparam int DAC_W = 12;

  // Function select pin codes for the parallel data path.
  typedef enum logic [3:0]
  {
    SCR_FSEL_FREQ = 4'h0,
    SCR_FSEL_PHASE = 4'h1,
    SCR_FSEL_AMP = 4'h2
  } scr_fsel_t;

endpackage : scr_pkg

// File: src/scr_store_if.sv
// Link between the bank control logic and its word store.
// Assumes both ends run on the same core sync clock.
`timescale 1ns/1ps
`default_nettype none
interface scr_store_if;
  logic we;
  logic [4:0] widx;
  logic [1:0] lane;
  logic [7:0] wdata;
  logic [4:0] ridx;
  logic [31:0] rdata;

  modport ctrl (output we, output widx, output lane, output wdata, output ridx, input rdata);
  modport store (input we, input widx, input lane, input wdata, input ridx, output rdata);
endinterface : scr_store_if
`default_nettype wire

// File: src/scr_store.sv
// Byte-writable store for the registers that carry no logic of their own.
// Assumes the control side only writes in-range indices; read data comes one clock after the index.
`timescale 1ns/1ps
`default_nettype none
module scr_store
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control side.
  scr_store_if.store bus
);
  import scr_pkg::*;

  logic [31:0] mem_r [REG_COUNT];
  logic [31:0] rdata_r;

  // One word per entry; master reset clears each back to its default.
  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++)
    begin : g_word
      always_ff @(posedge i_clk)
      begin
        if (i_sys_rst)
          mem_r[g] <= RST_OTHER;
        else if (bus.we && (bus.widx == 5'(g)))
          mem_r[g][{bus.lane, 3'b000} +: 8] <= bus.wdata;
      end
    end
  endgenerate

  // Registered read; an index past the end reads zero.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rdata_r <= RST_OTHER;
    else
      rdata_r <= (bus.ridx < REG_COUNT) ? mem_r[bus.ridx] : RST_OTHER;
  end

  assign bus.rdata = rdata_r;

endmodule : scr_store
`default_nettype wire

// File: src/scr_top.sv
// Configuration register bank of the synthesizer with its byte programming port.
// Assumes pin inputs are asynchronous except the parallel data and function select pins,
// which the host drives in step with the core sync clock.
`timescale 1ns/1ps
`default_nettype none
module scr_top
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Byte programming port.
  input wire logic [scr_pkg::BYTE_AW-1:0] i_prog_addr,
  input wire logic [7:0] i_prog_wdata,
  input wire logic i_prog_wr,
  output logic [7:0] o_prog_rdata,
  // Transfer pins.
  input wire logic i_io_update,
  input wire logic [2:0] i_profile_sel,
  // Parallel data path.
  input wire logic [scr_pkg::FREQ_W-1:0] i_par_data,
  input wire scr_pkg::scr_fsel_t i_function_select_pins,
  // Synthesizer core and clock generator.
  input wire logic [scr_pkg::DAC_W-1:0] i_dds_sine,
  input wire logic [scr_pkg::DAC_W-1:0] i_dds_cosine,
  input wire logic i_pll_lock,
  // Applied settings.
  output logic [scr_pkg::DAC_W-1:0] o_dac_data,
  output logic o_sine_select,
  output logic o_stream_enable,
  output logic o_oscillator_calibration_start,
  output logic [scr_pkg::FREQ_W-1:0] o_frequency_tuning_word,
  output logic [scr_pkg::PHASE_W-1:0] o_phase_offset_word,
  output logic [scr_pkg::AMP_W-1:0] o_amplitude_word,
  output logic [scr_pkg::PHASE_W-1:0] o_profile_seven_phase,
  output logic [scr_pkg::AMP_W-1:0] o_profile_seven_amp,
  output logic o_cal_with_sync,
  output logic [scr_pkg::DELAY_W-1:0] o_sync_out_delay,
  output logic [scr_pkg::DELAY_W-1:0] o_sync_in_delay
);
  import scr_pkg::*;

  localparam int SYNC_W = BYTE_AW + 8 + 1 + 1 + 3 + 1;

  // Replaces old bits with one byte lane of new data, only where the mask allows.
  function automatic logic [31:0] merge_byte(input logic [31:0] old, input logic [1:0] lane,
                                             input logic [7:0] d, input logic [31:0] mask);
    logic [31:0] lm;
    logic [31:0] dv;
    lm = (32'h0000_00ff << {lane, 3'b000}) & mask;
    dv = {24'h00_0000, d} << {lane, 3'b000};
    merge_byte = (old & ~lm) | (dv & lm);
  endfunction : merge_byte

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic wr_d_r;
  logic upd_d_r;
  logic [2:0] prof_d_r;
  logic [31:0] ctrl_buf_r;
  logic [31:0] ctrl_act_r;
  logic [31:0] prof_buf_r;
  logic [31:0] prof_act_r;
  logic [31:0] usync_buf_r;
  logic [31:0] usync_act_r;
  logic [FREQ_W-1:0] freq_r;
  logic [PHASE_W-1:0] phase_r;
  logic [AMP_W-1:0] amp_r;
  logic [DAC_W-1:0] dac_r;
  logic cal_r;
  logic [7:0] rdata_r;

  scr_store_if sbus ();

  scr_store u_store
  (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .bus(sbus.store)
  );

  // Every asynchronous pin passes two flip-flops before anything reads it.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= {i_prog_addr, i_prog_wdata, i_prog_wr, i_io_update, i_profile_sel, i_pll_lock};
      sync_r <= meta_r;
    end
  end

  // Synchronised pin views.
  wire [BYTE_AW-1:0] s_addr = sync_r[SYNC_W-1 -: BYTE_AW];
  wire [7:0] s_wdata = sync_r[13 -: 8];
  wire s_wr = sync_r[5];
  wire s_upd = sync_r[4];
  wire [2:0] s_prof = sync_r[3:1];
  wire s_lock = sync_r[0];

  // Address decode of the byte port into word index and byte lane.
  wire [IDX_W-1:0] idx = s_addr[BYTE_AW-1:2];
  wire [1:0] lane = s_addr[1:0];
  wire in_range = (s_addr < BYTE_COUNT);
  wire wr_pulse = s_wr & ~wr_d_r & in_range;
  wire hit_ctrl = (idx == IDX_CONTROL_WORD_ONE);
  wire hit_prof = (idx == IDX_PROFILE_SEVEN_PA);
  wire hit_usync = (idx == IDX_USER_SYNC_CONTROL);
  wire hit_own = hit_ctrl | hit_prof | hit_usync;

  // A transfer is an update rising edge or any change of the profile pins.
  wire xfer = (s_upd & ~upd_d_r) | (s_prof != prof_d_r);
  wire stream = ctrl_act_r[BIT_STREAM_ENABLE];
  wire load_par = stream | xfer;

  // Edge history for the write strobe and the transfer pins.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wr_d_r <= 1'b0;
      upd_d_r <= 1'b0;
      prof_d_r <= 3'h0;
    end
    else
    begin
      wr_d_r <= s_wr;
      upd_d_r <= s_upd;
      prof_d_r <= s_prof;
    end
  end

  // Host writes land in the buffer copies; open positions keep their zero.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_buf_r <= RST_CONTROL_WORD_ONE;
      prof_buf_r <= RST_PROFILE_SEVEN_PA;
      usync_buf_r <= RST_USER_SYNC_CONTROL;
    end
    else if (wr_pulse)
    begin
      if (hit_ctrl)
        ctrl_buf_r <= merge_byte(ctrl_buf_r, lane, s_wdata, MASK_CONTROL_WORD_ONE);
      if (hit_prof)
        prof_buf_r <= merge_byte(prof_buf_r, lane, s_wdata, MASK_PROFILE_SEVEN_PA);
      if (hit_usync)
        usync_buf_r <= merge_byte(usync_buf_r, lane, s_wdata, MASK_USER_SYNC_CONTROL);
    end
  end

  // Buffered values reach the logic only on a transfer; a same-cycle write waits for the next.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_act_r <= RST_CONTROL_WORD_ONE;
      prof_act_r <= RST_PROFILE_SEVEN_PA;
      usync_act_r <= RST_USER_SYNC_CONTROL;
      cal_r <= 1'b0;
    end
    else
    begin
      if (xfer)
      begin
        ctrl_act_r <= ctrl_buf_r;
        prof_act_r <= prof_buf_r;
        usync_act_r <= usync_buf_r;
      end
      // Only a zero-to-one step starts a calibration, so the host must clear the bit between runs.
      cal_r <= xfer & ctrl_buf_r[BIT_OSC_CAL_START] & ~ctrl_act_r[BIT_OSC_CAL_START];
    end
  end

  // Parallel data goes to the word picked by the function select pins.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      freq_r <= '0;
      phase_r <= '0;
      amp_r <= '0;
    end
    else if (load_par)
    begin
      if (i_function_select_pins == SCR_FSEL_FREQ)
        freq_r <= i_par_data;
      if (i_function_select_pins == SCR_FSEL_PHASE)
        phase_r <= i_par_data[PHASE_W-1:0];
      if (i_function_select_pins == SCR_FSEL_AMP)
        amp_r <= i_par_data[AMP_W-1:0];
    end
  end

  // Converter source: sine when the select bit is one, cosine when zero.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      dac_r <= '0;
    else
      dac_r <= ctrl_act_r[BIT_SINE_SELECT] ? i_dds_sine : i_dds_cosine;
  end

  // Store side carries every register this logic does not decode.
  assign sbus.we = wr_pulse & ~hit_own;
  assign sbus.widx = idx;
  assign sbus.lane = lane;
  assign sbus.wdata = s_wdata;
  assign sbus.ridx = idx;

  // Readback shows buffered values, with the lock flag live from the pin.
  wire [31:0] usync_rd = usync_buf_r | ({31'h0, s_lock} << BIT_PLL_LOCK);
  wire [31:0] rd_word = hit_ctrl ? ctrl_buf_r : hit_prof ? prof_buf_r : hit_usync ? usync_rd : sbus.rdata;
  wire [7:0] rd_byte = in_range ? rd_word[{lane, 3'b000} +: 8] : 8'h00;

  // Read data is registered; it follows the address a few clocks late.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rdata_r <= 8'h00;
    else
      rdata_r <= rd_byte;
  end

  assign o_prog_rdata = rdata_r;
  assign o_dac_data = dac_r;
  assign o_sine_select = ctrl_act_r[BIT_SINE_SELECT];
  assign o_stream_enable = stream;
  assign o_oscillator_calibration_start = cal_r;
  assign o_frequency_tuning_word = freq_r;
  assign o_phase_offset_word = phase_r;
  assign o_amplitude_word = amp_r;
  assign o_profile_seven_phase = prof_act_r[POS_PHASE +: PHASE_W];
  assign o_profile_seven_amp = prof_act_r[POS_AMP +: AMP_W];
  assign o_cal_with_sync = usync_act_r[BIT_CAL_WITH_SYNC];
  assign o_sync_out_delay = usync_act_r[POS_SYNC_OUT_DELAY +: DELAY_W];
  assign o_sync_in_delay = usync_act_r[POS_SYNC_IN_DELAY +: DELAY_W];

endmodule : scr_top
`default_nettype wire

// File: bench/scr_properties.sv
// Concurrent checks on the register bank ports.
// Assumes it is bound to the bank top module and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module scr_properties
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Watched pins.
  input wire logic [6:0] i_prog_addr,
  input wire logic [7:0] o_prog_rdata,
  input wire logic i_io_update,
  input wire logic [2:0] i_profile_sel,
  input wire logic [31:0] i_par_data,
  input wire scr_pkg::scr_fsel_t i_function_select_pins,
  input wire logic [11:0] i_dds_sine,
  input wire logic [11:0] i_dds_cosine,
  input wire logic [11:0] o_dac_data,
  input wire logic o_sine_select,
  input wire logic o_stream_enable,
  input wire logic o_oscillator_calibration_start,
  input wire logic [31:0] o_frequency_tuning_word,
  input wire logic [15:0] o_phase_offset_word
);
  import scr_pkg::*;
  // One clock domain, so reset masks every check here.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_RESET: assert property ($past(i_sys_rst) |-> o_sine_select && !o_stream_enable)
    else $error("reset state wrong");
  AST_DAC: assert property (!$past(i_sys_rst) |->
    o_dac_data == ($past(o_sine_select) ? $past(i_dds_sine) : $past(i_dds_cosine)))
    else $error("converter source wrong");
  AST_STREAM_FREQ: assert property (o_stream_enable && i_function_select_pins == SCR_FSEL_FREQ |=>
    o_frequency_tuning_word == $past(i_par_data)) else $error("streamed frequency missed");
  AST_STREAM_PHASE: assert property (o_stream_enable && i_function_select_pins == SCR_FSEL_PHASE |=>
    o_phase_offset_word == $past(i_par_data[15:0])) else $error("streamed phase missed");
  // With streaming off, quiet transfer pins must leave the frequency tuning word alone.
  AST_HOLD: assert property ((!i_io_update && $stable(i_profile_sel))[*4] ##0 !o_stream_enable |=>
    $stable(o_frequency_tuning_word)) else $error("word moved without transfer");
  AST_CAL: assert property (o_oscillator_calibration_start |=> !o_oscillator_calibration_start)
    else $error("calibration start too long");
  AST_OPEN_P7: assert property ($stable(i_prog_addr)[*6] ##0 i_prog_addr == 7'h6b |->
    o_prog_rdata[7:4] == 4'h0) else $error("open bits read back");
  AST_RANGE: assert property ($stable(i_prog_addr)[*6] ##0 i_prog_addr >= 7'h70 |->
    o_prog_rdata == 8'h00) else $error("out of range read not zero");

  // Main scenarios reached.
  CV_CAL: cover property (o_oscillator_calibration_start);
  CV_COS: cover property (!o_sine_select);
  CV_STREAM: cover property (o_stream_enable && i_function_select_pins == SCR_FSEL_PHASE);
endmodule : scr_properties
`default_nettype wire

// File: bench/scr_host_model.sv
// Host controller model for the byte programming port and transfer pins.
// Assumes the bench calls its tasks only after reset is released.
`timescale 1ns/1ps
`default_nettype none
module scr_host_model
(
  // Clock and readback.
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  // Pins toward the bank.
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_upd,
  output logic [2:0] o_prof
);
  // Pins start low so reset release sees no edge.
  initial {o_addr, o_wdata, o_wr, o_upd, o_prof} = '0;

  // One byte write; address and data settle three clocks before the strobe.
  task put(input logic [6:0] a, input logic [7:0] d);
  begin
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    repeat (3) @(posedge i_clk);
    o_wr <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_wr <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_wdata <= ~d; // A released bus must not keep showing the byte.
  end
  endtask : put

  // Readback waits past the synchroniser and store latency.
  task rd(input logic [6:0] a, output logic [7:0] d);
  begin
    @(posedge i_clk);
    o_addr <= a;
    repeat (7) @(posedge i_clk);
    d = i_rdata;
  end
  endtask : rd

  // Transfer strobe, high two clocks and low long enough to land.
  task upd;
  begin
    @(posedge i_clk);
    o_upd <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_upd <= 1'b0;
    repeat (4) @(posedge i_clk);
  end
  endtask : upd

  // Profile pin change, which also transfers.
  task prof(input logic [2:0] p);
  begin
    @(posedge i_clk);
    o_prof <= p;
    repeat (6) @(posedge i_clk);
  end
  endtask : prof
endmodule : scr_host_model
`default_nettype wire

// File: bench/scr_top_bench.sv
// Self-checking bench for the configuration register bank.
// Assumes the bank top, the host model and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
module scr_top_bench;
  import scr_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [6:0] i_prog_addr;
  logic [7:0] i_prog_wdata, o_prog_rdata, rb;
  logic i_prog_wr, i_io_update, i_pll_lock = 1'b1;
  logic [2:0] i_profile_sel, o_sync_out_delay, o_sync_in_delay;
  logic [31:0] i_par_data = 32'h0, o_frequency_tuning_word;
  scr_fsel_t i_function_select_pins = SCR_FSEL_FREQ;
  logic [11:0] i_dds_sine = 12'habc, i_dds_cosine = 12'h123, o_dac_data, o_amplitude_word, o_profile_seven_amp;
  logic [15:0] o_phase_offset_word, o_profile_seven_phase;
  logic o_sine_select, o_stream_enable, o_oscillator_calibration_start, o_cal_with_sync;
  int n_fail = 0, n_tests = 0, n_cyc = 0, n_cal = 0;
  // Address, byte written, byte read back; 0x6d/0x6e get only their fixed settings.
  logic [22:0] rows [12] = '{{7'h6c, 8'hff, 8'h7f}, {7'h6d, 8'h08, 8'h08}, {7'h6e, 8'h00, 8'h00},
    {7'h6f, 8'hff, 8'h01}, {7'h6b, 8'hff, 8'h0f}, {7'h6a, 8'h34, 8'h34}, {7'h68, 8'ha5, 8'ha5},
    {7'h01, 8'hff, 8'hfb}, {7'h03, 8'hfe, 8'h00}, {7'h10, 8'h3c, 8'h3c}, {7'h70, 8'h55, 8'h00},
    {7'h7f, 8'haa, 8'h00}};

  initial forever #4 i_clk = ~i_clk;

  scr_top scr_top_i (.i_clk, .i_sys_rst, .i_prog_addr, .i_prog_wdata, .i_prog_wr, .o_prog_rdata, .i_io_update,
    .i_profile_sel, .i_par_data, .i_function_select_pins, .i_dds_sine, .i_dds_cosine, .i_pll_lock, .o_dac_data,
    .o_sine_select, .o_stream_enable, .o_oscillator_calibration_start, .o_frequency_tuning_word,
    .o_phase_offset_word, .o_amplitude_word, .o_profile_seven_phase, .o_profile_seven_amp, .o_cal_with_sync,
    .o_sync_out_delay, .o_sync_in_delay);
  scr_host_model scr_host_model_i (.i_clk, .i_rdata(o_prog_rdata), .o_addr(i_prog_addr), .o_wdata(i_prog_wdata),
    .o_wr(i_prog_wr), .o_upd(i_io_update), .o_prof(i_profile_sel));

  // Compare and count; unknowns never match.
  task chk(input logic [31:0] s, input logic [31:0] e);
  begin
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  end
  endtask : chk

  task finish_test;
  begin
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask : finish_test

  // Cycle ceiling well above the roughly 370 cycles the tests need; also counts calibration pulses.
  always @(posedge i_clk)
  begin
    n_cyc++;
    if (o_oscillator_calibration_start === 1'b1)
      n_cal++;
    if (n_cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // Reset, table of byte accesses, then the hand-written cases.
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(o_sine_select, 1'b1);
    scr_host_model_i.rd(7'h6d, rb);
    chk(rb, 8'h08);
    scr_host_model_i.rd(7'h02, rb);
    chk(rb, 8'h01);
    foreach (rows[k])
    begin
      scr_host_model_i.put(rows[k][22:16], rows[k][15:8]);
      scr_host_model_i.rd(rows[k][22:16], rb);
      chk(rb, rows[k][7:0]);
    end
    chk(o_profile_seven_phase, 16'h0);
    scr_host_model_i.upd();
    chk(o_profile_seven_phase, 16'h00a5);
    chk(o_profile_seven_amp, 12'hf34);
    chk({o_cal_with_sync, o_sync_out_delay, o_sync_in_delay}, 7'h7f);
    scr_host_model_i.put(7'h02, 8'h00);
    scr_host_model_i.upd();
    chk(o_dac_data, 12'h123);
    scr_host_model_i.put(7'h02, 8'h01);
    scr_host_model_i.upd();
    chk(o_dac_data, 12'habc);
    i_par_data <= 32'hdeadbeef;
    repeat (5) @(posedge i_clk);
    chk(o_frequency_tuning_word, 32'h0);
    scr_host_model_i.upd();
    chk(o_frequency_tuning_word, 32'hdeadbeef);
    // Streaming, back to back through every select code.
    scr_host_model_i.put(7'h02, 8'h03);
    scr_host_model_i.upd();
    chk(o_stream_enable, 1'b1);
    i_par_data <= 32'h12345678;
    @(posedge i_clk);
    i_function_select_pins <= SCR_FSEL_PHASE;
    i_par_data <= 32'h00009abc;
    @(posedge i_clk);
    i_function_select_pins <= SCR_FSEL_AMP;
    i_par_data <= 32'h00000def;
    @(posedge i_clk);
    i_function_select_pins <= scr_fsel_t'(4'h3);
    i_par_data <= 32'h55555555;
    repeat (3) @(posedge i_clk);
    chk(o_frequency_tuning_word, 32'h12345678);
    chk(o_phase_offset_word, 16'h9abc);
    chk(o_amplitude_word, 12'hdef);
    scr_host_model_i.put(7'h03, 8'h01);
    scr_host_model_i.upd();
    scr_host_model_i.upd();
    chk(n_cal, 1);
    scr_host_model_i.put(7'h03, 8'h00); // The bit goes back to zero before another start.
    scr_host_model_i.upd();
    scr_host_model_i.put(7'h03, 8'h01);
    scr_host_model_i.upd();
    chk(n_cal, 2);
    scr_host_model_i.put(7'h68, 8'h5a);
    scr_host_model_i.prof(3'h5);
    chk(o_profile_seven_phase, 16'h005a);
    finish_test();
  end
endmodule : scr_top_bench

bind scr_top scr_properties scr_properties_i (.i_clk, .i_sys_rst, .i_prog_addr, .o_prog_rdata, .i_io_update,
  .i_profile_sel, .i_par_data, .i_function_select_pins, .i_dds_sine, .i_dds_cosine, .o_dac_data, .o_sine_select,
  .o_stream_enable, .o_oscillator_calibration_start, .o_frequency_tuning_word, .o_phase_offset_word);
`default_nettype wire
